// *** hw/wake_pkg.sv ***
/*
 Package of the wake input detector: register offsets, field positions,
 reset values, device mode codes and filter timing counts.
 Assumes a 200 MHz clock.
*/
package wake_pkg;
   // Register offsets
   localparam logic [7:0] OFS_WAKE_EN = 8'h00;
   localparam logic [7:0] OFS_SRC_A = 8'h01;
   localparam logic [7:0] OFS_SRC_B = 8'h02;
   localparam logic [7:0] OFS_LEVEL = 8'h03;
   localparam logic [7:0] OFS_PULL = 8'h04;
   localparam logic [7:0] OFS_DETECT = 8'h05;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h06;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h07;
   // Field positions in the enable register
   localparam int WEN_PIN_POS = 0;
   localparam int WEN_ALT_POS = 3;
   // Pull field codes
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_DOWN = 2'h1;
   localparam logic [1:0] PULL_UP = 2'h2;
   localparam logic [1:0] PULL_AUTO = 2'h3;
   // Detect field codes
   localparam logic [1:0] DET_STATIC_SHORT = 2'h0;
   localparam logic [1:0] DET_STATIC_LONG = 2'h1;
   localparam logic [1:0] DET_CYCLIC_A = 2'h2;
   localparam logic [1:0] DET_CYCLIC_B = 2'h3;
   // Reset values
   localparam logic [4:0] RST_WAKE_EN = 5'h00;
   localparam logic [5:0] RST_PULL = 6'h00;
   localparam logic [5:0] RST_DETECT = 6'h00;
   localparam logic [4:0] RST_IRQ_MASK = 5'h00;
   // Device operating modes
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_STOP = 2'h1;
   localparam logic [1:0] MODE_SLEEP = 2'h2;
   localparam logic [1:0] MODE_FAILSAFE = 2'h3;
   // Timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SHORT_FILTER_US = 16;
   localparam int LONG_FILTER_US = 64;
   localparam int SHORT_FILTER_CYC =
      (SHORT_FILTER_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LONG_FILTER_CYC =
      (LONG_FILTER_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 14;
   localparam logic [1:0] INIT_DONE = 2'h3;
endpackage

// *** hw/wake_input_detector.sv ***
/*
 Wake input detector: three wake pins plus two alternate pins, each with
 a three-stage synchroniser, a glitch filter, wake source status and an
 interrupt; the wake pins also have static or cyclic sensing, level status and pull control.
 Assumes the cyclic timer windows and the device mode come from logic on
 mclk, and the pins come from outside and are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module wake_input_detector #(
   parameter int LONG_FILTER_CYC = wake_pkg::LONG_FILTER_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Pins and context
   input wire logic [2:0] wake_pin_n,
   input wire logic [1:0] alternate_output_pins,
   input wire logic [1:0] dev_mode,
   input wire logic cyclic_timer_a,
   input wire logic cyclic_timer_b,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   // Results
   output logic irq,
   output logic wake_req,
   output logic [2:0] pull_up_en,
   output logic [2:0] pull_dn_en
);
   localparam int NCH = 5;
   localparam int CW = wake_pkg::CNT_W;
   logic [4:0] s1_q, s2_q, s3_q, lvl_q, stable_q;
   logic [CW-1:0] cnt_q [NCH];
   logic [1:0] init_q;
   logic [4:0] wake_en_q;
   logic [5:0] pull_q, detect_q;
   logic [2:0] src_a_q, level_q;
   logic [1:0] src_b_q;
   logic [4:0] irq_stat_q, irq_mask_q;
   logic [4:0] on, evt, hit;
   logic [CW-1:0] lim [NCH];
   logic awake, asleep;
   // Filter length of one channel in cycles
   function automatic logic [CW-1:0] chan_lim(input int ch,
                                              input logic [5:0] det);
      logic [CW-1:0] r;
      r = CW'(wake_pkg::SHORT_FILTER_CYC);
      if (ch < 3 && det[2*(ch%3) +: 2] == wake_pkg::DET_STATIC_LONG)
         r = CW'(LONG_FILTER_CYC);
      return r;
   endfunction
   // Whether a channel is being sensed this cycle
   function automatic logic chan_on(input int ch, input logic [5:0] det,
                                    input logic [4:0] wen,
                                    input logic ta, input logic tb);
      logic [1:0] c;
      logic r;
      c = det[2*(ch%3) +: 2];
      r = 1'b1;
      if (ch >= 3)
         r = wen[wake_pkg::WEN_ALT_POS + ch - 3];
      else if (c == wake_pkg::DET_CYCLIC_A)
         r = ta;
      else if (c == wake_pkg::DET_CYCLIC_B)
         r = tb;
      return r;
   endfunction
   // Register write strobe for one offset
   function automatic logic wsel(input logic [7:0] a, input logic w,
                                 input logic [7:0] ofs);
      return w && (a == ofs);
   endfunction

   // ************************************************
   // Input synchronisers
   // ************************************************
   // Three stages; the level moves once stages two and three agree
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s1_q <= 5'h00;
         s2_q <= 5'h00;
         s3_q <= 5'h00;
         lvl_q <= 5'h00;
      end
      else
      begin
         s1_q <= {alternate_output_pins, wake_pin_n};
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
      end
   end

   // Settling time after reset before edges count
   always_ff @(posedge mclk)
   begin
      if (rst)
         init_q <= 2'h0;
      else if (init_q != wake_pkg::INIT_DONE)
         init_q <= init_q + 2'h1;
   end

   // ************************************************
   // Glitch filters
   // ************************************************
   // Per-channel enable, limit and event
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         on[i] = chan_on(i, detect_q, wake_en_q, cyclic_timer_a,
                         cyclic_timer_b);
         lim[i] = chan_lim(i, detect_q);
         evt[i] = (init_q == wake_pkg::INIT_DONE) && on[i] &&
                  (lvl_q[i] != stable_q[i]) &&
                  (cnt_q[i] == lim[i] - CW'(1));
      end
   end

   // Count while the level differs from the accepted one
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         stable_q <= 5'h00;
         for (int i = 0; i < NCH; i++)
            cnt_q[i] <= '0;
      end
      else
      begin
         for (int i = 0; i < NCH; i++)
         begin
            if (init_q != wake_pkg::INIT_DONE)
            begin
               stable_q[i] <= lvl_q[i];
               cnt_q[i] <= '0;
            end
            else if (!on[i] || lvl_q[i] == stable_q[i])
               cnt_q[i] <= '0; // crossing back discards
            else if (evt[i])
            begin
               stable_q[i] <= lvl_q[i];
               cnt_q[i] <= '0;
            end
            else
               cnt_q[i] <= cnt_q[i] + CW'(1);
         end
      end
   end

   // ************************************************
   // Wake and interrupt
   // ************************************************
   assign awake = (dev_mode == wake_pkg::MODE_NORMAL) ||
                  (dev_mode == wake_pkg::MODE_STOP);
   assign asleep = !awake;
   assign hit = evt & {wake_en_q[4:3], wake_en_q[2:0]};

   // Wake source status, set wins over write-one-to-clear
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         src_a_q <= 3'h0;
         src_b_q <= 2'h0;
      end
      else
      begin
         src_a_q <= (src_a_q &
                     ~(wsel(addr, wr_en, wake_pkg::OFS_SRC_A) ?
                       wr_data[2:0] : 3'h0))
                    | hit[2:0];
         src_b_q <= (src_b_q &
                     ~(wsel(addr, wr_en, wake_pkg::OFS_SRC_B) ?
                       wr_data[1:0] : 2'h0))
                    | hit[4:3];
      end
   end

   // Interrupt status in the awake modes
   always_ff @(posedge mclk)
   begin
      if (rst)
         irq_stat_q <= 5'h00;
      else
         irq_stat_q <= (irq_stat_q &
                        ~(wsel(addr, wr_en, wake_pkg::OFS_IRQ_STAT) ?
                          wr_data[4:0] : 5'h00))
                       | (awake ? hit : 5'h00);
   end

   // Interrupt line and wake request
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         irq <= 1'b0;
         wake_req <= 1'b0;
      end
      else
      begin
         irq <= |(irq_stat_q & irq_mask_q);
         if (asleep && |hit)
            wake_req <= 1'b1;
         else if (awake)
            wake_req <= 1'b0;
      end
   end

   // ************************************************
   // Level status and pulls
   // ************************************************
   // In the awake modes, live level when static, last window sample when cyclic
   always_ff @(posedge mclk)
   begin
      if (rst)
         level_q <= 3'h0;
      else if (awake)
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (on[i])
               level_q[i] <= lvl_q[i];
         end
      end
   end

   // Pull current sources per pin
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pull_up_en <= 3'h0;
         pull_dn_en <= 3'h0;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            unique case (pull_q[2*i +: 2])
               wake_pkg::PULL_NONE:
               begin
                  pull_up_en[i] <= 1'b0;
                  pull_dn_en[i] <= 1'b0;
               end
               wake_pkg::PULL_DOWN:
               begin
                  pull_up_en[i] <= 1'b0;
                  pull_dn_en[i] <= 1'b1;
               end
               wake_pkg::PULL_UP:
               begin
                  pull_up_en[i] <= 1'b1;
                  pull_dn_en[i] <= 1'b0;
               end
               wake_pkg::PULL_AUTO:
               begin
                  pull_up_en[i] <= lvl_q[i];
                  pull_dn_en[i] <= !lvl_q[i];
               end
            endcase
         end
      end
   end

   // ************************************************
   // Register port
   // ************************************************
   // Configuration registers
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wake_en_q <= wake_pkg::RST_WAKE_EN;
         pull_q <= wake_pkg::RST_PULL;
         detect_q <= wake_pkg::RST_DETECT;
         irq_mask_q <= wake_pkg::RST_IRQ_MASK;
      end
      else if (wr_en)
      begin
         if (addr == wake_pkg::OFS_WAKE_EN)
            wake_en_q <= wr_data[4:0];
         if (addr == wake_pkg::OFS_PULL)
            pull_q <= wr_data[5:0];
         if (addr == wake_pkg::OFS_DETECT)
            detect_q <= wr_data[5:0];
         if (addr == wake_pkg::OFS_IRQ_MASK)
            irq_mask_q <= wr_data[4:0];
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk)
   begin
      if (rst || !rd_en)
         rd_data <= 8'h00;
      else
      begin
         unique case (addr)
            wake_pkg::OFS_WAKE_EN: rd_data <= {3'h0, wake_en_q};
            wake_pkg::OFS_SRC_A: rd_data <= {5'h00, src_a_q};
            wake_pkg::OFS_SRC_B: rd_data <= {6'h00, src_b_q};
            wake_pkg::OFS_LEVEL: rd_data <= {5'h00, level_q};
            wake_pkg::OFS_PULL: rd_data <= {2'h0, pull_q};
            wake_pkg::OFS_DETECT: rd_data <= {2'h0, detect_q};
            wake_pkg::OFS_IRQ_STAT: rd_data <= {3'h0, irq_stat_q};
            wake_pkg::OFS_IRQ_MASK: rd_data <= {3'h0, irq_mask_q};
            default: rd_data <= 8'h00;
         endcase
      end
   end
endmodule

`default_nettype wire

// *** sim/wake_input_detector_sva.sv ***
/*
 Port checker for the wake input detector.
 Assumes the detector's port names and a single mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module wake_input_detector_sva #(
   parameter int LONG_FILTER_CYC = wake_pkg::LONG_FILTER_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Watched ports
   input wire logic [1:0] dev_mode,
   input wire logic [7:0] addr,
   input wire logic rd_en,
   input wire logic [7:0] rd_data,
   input wire logic irq,
   input wire logic wake_req,
   input wire logic [2:0] pull_up_en,
   input wire logic [2:0] pull_dn_en
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   // ********************
   // Port relations
   // ********************
   a_rd_idle_zero: assert property (!rd_en |=> rd_data == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (rd_en && addr > 8'h07
      |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_level_width: assert property (rd_en
      && addr == wake_pkg::OFS_LEVEL |=> rd_data[7:3] == 5'h00)
      else $error("level status upper bits set");
   a_srcb_width: assert property (rd_en
      && addr == wake_pkg::OFS_SRC_B |=> rd_data[7:2] == 6'h00)
      else $error("second status upper bits set");
   a_pull_exclusive: assert property (
      (pull_up_en & pull_dn_en) == 3'h0)
      else $error("pull up and down both on");
   a_awake_no_wake: assert property (!dev_mode[1] |=> !wake_req)
      else $error("wake request while awake");
   a_wake_in_sleep: assert property ($rose(wake_req)
      |-> $past(dev_mode[1]))
      else $error("wake request rose outside sleep");
   a_reset_quiet: assert property ($fell(rst) |-> (!wake_req
      && pull_up_en == 3'h0 && pull_dn_en == 3'h0) [*2])
      else $error("outputs active after reset");
   a_no_early_irq: assert property ($fell(rst) |-> !irq [*8])
      else $error("interrupt without filtered event");
   // Main scenarios seen
   c_irq: cover property ($rose(irq));
   c_wake: cover property ($rose(wake_req));
   c_pull: cover property (pull_up_en != 3'h0);
endmodule
bind wake_input_detector wake_input_detector_sva #(
   .LONG_FILTER_CYC(LONG_FILTER_CYC)
) u_sva (.mclk(mclk), .rst(rst), .dev_mode(dev_mode), .addr(addr),
   .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .wake_req(wake_req),
   .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en));
`default_nettype wire

// *** sim/wake_switches.sv ***
/*
 Model of the switches on the wake pins.
 Assumes open pins are pulled by the detector or tied low on the board.
*/
`timescale 1ns/1ps
`default_nettype none
module wake_switches (
   // Switch commands
   input wire logic [4:0] sw_level,
   input wire logic [4:0] sw_on,
   // Pull sources
   input wire logic [2:0] pull_up_en,
   // Pins
   output logic [2:0] wake_pin_n,
   output logic [1:0] alternate_output_pins
);
   // Open switch: pull-up wins, else the board tie holds it low
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         wake_pin_n[i] = sw_on[i] ? sw_level[i] : pull_up_en[i];
      alternate_output_pins = sw_level[4:3];
   end
endmodule
`default_nettype wire

// *** sim/test_wake_input_detector.sv ***
/*
 Testbench of the wake input detector: register tasks and sequences.
 Assumes a short long-filter parameter of 40 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module test_wake_input_detector;
   localparam logic [7:0] EN = wake_pkg::OFS_WAKE_EN;
   localparam logic [7:0] SA = wake_pkg::OFS_SRC_A;
   localparam logic [7:0] LV = wake_pkg::OFS_LEVEL;
   localparam logic [7:0] DT = wake_pkg::OFS_DETECT;
   logic mclk, rst, wr_en, rd_en, ta, tb, irq, wake_req;
   logic [1:0] dev_mode, alt;
   logic [7:0] addr, wr_data, rd_data;
   logic [2:0] pull_up_en, pull_dn_en, pins;
   logic [4:0] lvl, on;
   int errors, compares;
   wake_input_detector #(.LONG_FILTER_CYC(40)) dut (.mclk(mclk), .rst(rst),
      .wake_pin_n(pins), .alternate_output_pins(alt), .dev_mode(dev_mode),
      .cyclic_timer_a(ta), .cyclic_timer_b(tb), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .irq(irq), .wake_req(wake_req), .pull_up_en(pull_up_en),
      .pull_dn_en(pull_dn_en));
   wake_switches sw (.sw_level(lvl), .sw_on(on), .pull_up_en(pull_up_en),
      .wake_pin_n(pins), .alternate_output_pins(alt));
   // ********************
   // Tasks
   // ********************
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task setp(input logic [4:0] v);
      @(posedge mclk);
      lvl <= v;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 chk(rd_data, exp);
   endtask
   task test_done;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Watchdog, about 2.4 times the expected run
   initial
   begin
      #400000;
      errors++;
      test_done;
   end
   // ********************
   // Sequence
   // ********************
   initial
   begin
      {rst, wr_en, rd_en, ta, tb, addr, wr_data} = {5'h10, 16'h0000};
      dev_mode = wake_pkg::MODE_NORMAL;
      lvl = 5'h00;
      on = 5'h1F;
      errors = 0;
      compares = 0;
      cyc(20);
      rst <= 1'b0;
      cyc(8);
      rd(EN, 8'h00);
      rd(wake_pkg::OFS_PULL, 8'h00);
      rd(DT, 8'h00);
      rd(8'h08, 8'h00);
      setp(5'h04);
      cyc(3300);
      rd(LV, 8'h04);
      rd(SA, 8'h00);
      wr(EN, 8'h07);
      wr(wake_pkg::OFS_IRQ_MASK, 8'h1F);
      setp(5'h06);
      cyc(100);
      setp(5'h04);
      cyc(3300);
      rd(SA, 8'h00);
      setp(5'h05);
      cyc(3300);
      rd(SA, 8'h01);
      chk({7'h00, irq}, 8'h01);
      setp(5'h01);
      cyc(3300);
      rd(SA, 8'h05);
      wr(SA, 8'h01);
      rd(SA, 8'h04);
      wr(SA, 8'h04);
      wr(wake_pkg::OFS_IRQ_STAT, 8'h1F);
      cyc(2);
      #1 chk({7'h00, irq}, 8'h00);
      wr(DT, 8'h39);
      setp(5'h00);
      cyc(60);
      rd(SA, 8'h01);
      setp(5'h06);
      cyc(3300);
      rd(SA, 8'h01);
      rd(LV, 8'h00);
      @(posedge mclk);
      ta <= 1'b1;
      cyc(3300);
      ta <= 1'b0;
      rd(SA, 8'h03);
      @(posedge mclk);
      tb <= 1'b1;
      cyc(3300);
      tb <= 1'b0;
      rd(SA, 8'h07);
      setp(5'h00);
      cyc(3300);
      rd(LV, 8'h06);
      wr(SA, 8'h07);
      wr(wake_pkg::OFS_IRQ_STAT, 8'h1F);
      @(posedge mclk);
      dev_mode <= wake_pkg::MODE_SLEEP;
      setp(5'h01);
      cyc(60);
      #1 chk({6'h00, wake_req, irq}, 8'h02);
      @(posedge mclk);
      dev_mode <= wake_pkg::MODE_NORMAL;
      cyc(2);
      #1 chk({7'h00, wake_req}, 8'h00);
      wr(EN, 8'h0F);
      setp(5'h09);
      cyc(3300);
      rd(wake_pkg::OFS_SRC_B, 8'h01);
      wr(wake_pkg::OFS_PULL, 8'h3A);
      @(posedge mclk);
      on <= 5'h1E;
      lvl <= 5'h08;
      cyc(3300);
      #1 chk({2'h0, pull_up_en, pull_dn_en}, 8'h1C);
      rd(LV, 8'h07);
      rd(wake_pkg::OFS_IRQ_STAT, 8'h08);
      wr(wake_pkg::OFS_IRQ_MASK, 8'h17);
      rd(wake_pkg::OFS_IRQ_MASK, 8'h17);
      chk({7'h00, irq}, 8'h00);
      @(posedge mclk);
      dev_mode <= wake_pkg::MODE_STOP;
      wr(wake_pkg::OFS_PULL, 8'h15);
      cyc(60);
      #1 chk({wake_req, irq, pull_up_en, pull_dn_en}, 8'h47);
      @(posedge mclk);
      dev_mode <= wake_pkg::MODE_FAILSAFE;
      on <= 5'h1F;
      lvl <= 5'h09;
      cyc(60);
      #1 chk({wake_req, irq, 6'h00}, 8'hC0);
      test_done;
   end
endmodule
`default_nettype wire
